/* iem_top.sv */
// Input energy meter: current, voltage, power, energy and elapsed time.
// Assumes signed sense and unsigned supply codes from an ADC on clk_sys.
//
// Behaviour
// - Report amps, volts, watts, millijoules (milli units).
// - Tempco corrects resistance; zero means none.
// - Range field picks 100, 50, 20 mV.
// - Current equals sense voltage over programmed resistance.
// - Voltage reading follows supply sense pin code.
// - Power is latest voltage times latest current.
// - Power is signed, sign gives direction.
// - Twelve byte block: energy and elapsed time.
// - Both 48-bit counters wrap at full scale.
// - Negative power decrements energy, clamps at zero.
// - Internal time base integrates power to energy.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module iem_top
  import iem_pkg::*;
#(
  parameter int TICK_CYCLES = iem_pkg::IEM_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  // ADC samples
  input  wire logic        sample_valid,
  input  wire logic [15:0] supply_voltage_sense_pin,
  input  wire logic [15:0] iin_sense_code,
  input  wire logic [7:0]  die_temp_c,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  import iem_pkg::*;

  // Refuse time bases the counter cannot serve
  if (TICK_CYCLES < 2 || TICK_CYCLES > 1_000_000) begin : g_bad_tick
    $error("iem_top: TICK_CYCLES out of range");
  end

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // Configuration
  logic [1:0]  iin_range;
  logic [15:0] cal_gain;
  logic [15:0] sense_resistor_tempco;
  // Readings
  logic signed [31:0] iin_reading;
  logic [15:0]        input_voltage_reading;
  logic signed [31:0] pin_reading;
  logic [47:0]        energy_value;
  logic [47:0]        energy_time;
  logic signed [47:0] energy_frac;
  logic [15:0]        energy_hi_snap;
  logic [47:0]        time_snap;
  // Time base
  logic [TW-1:0]      tick_cnt;
  logic [15:0]        ms_since;
  // Datapath
  iem_state_t         state;
  logic [15:0]        vin_q;
  logic signed [15:0] code_q;
  logic signed [8:0]  temp_q;
  logic signed [17:0] sense_uv;
  logic [31:0]        den;
  logic [32:0]        rem;
  logic [31:0]        dq;
  logic [5:0]         step;
  logic               neg;

  // Bus decode
  wire        bus_req  = (avs_read | avs_write) & avs_waitrequest;
  wire        wr_acc   = bus_req & avs_write;
  wire        rd_acc   = bus_req & avs_read;
  wire        wr_ctrl  = wr_acc && avs_address == IEM_CTRL_OFS;
  wire        clear_e  = wr_ctrl & avs_writedata[IEM_CTRL_CLEAR_BIT];
  wire        snap_e   = rd_acc && avs_address == IEM_EVAL_LO_OFS;
  logic [31:0] rd_mux;
  always_comb begin
    if (avs_address == IEM_CTRL_OFS)
      rd_mux = {30'h0, iin_range};
    else if (avs_address == IEM_CAL_GAIN_OFS)
      rd_mux = {16'h0, cal_gain};
    else if (avs_address == IEM_TEMPCO_OFS)
      rd_mux = {16'h0, sense_resistor_tempco};
    else if (avs_address == IEM_IIN_OFS)
      rd_mux = iin_reading;
    else if (avs_address == IEM_VIN_OFS)
      rd_mux = {16'h0, input_voltage_reading};
    else if (avs_address == IEM_PIN_OFS)
      rd_mux = pin_reading;
    else if (avs_address == IEM_EVAL_LO_OFS)
      rd_mux = energy_value[31:0];
    else if (avs_address == IEM_EVAL_HI_OFS)
      rd_mux = {16'h0, energy_hi_snap};
    else if (avs_address == IEM_ETIME_LO_OFS)
      rd_mux = time_snap[31:0];
    else if (avs_address == IEM_ETIME_HI_OFS)
      rd_mux = {16'h0, time_snap[47:32]};
    else if (avs_address == IEM_STATUS_OFS)
      rd_mux = {31'h0, state != IEM_IDLE};
    else
      rd_mux = 32'h0;
  end

  function automatic logic [16:0] range_fs(input logic [1:0] r);
    if (r == IEM_RANGE_MED)
      range_fs = IEM_FS_MED_UV;
    else if (r == IEM_RANGE_LOW)
      range_fs = IEM_FS_LOW_UV;
    else
      range_fs = IEM_FS_HIGH_UV;
  endfunction

  // Scale stage arithmetic
  wire signed [33:0] uv_prod   = code_q * $signed({1'b0, range_fs(iin_range)});
  wire signed [17:0] next_uv   = 18'(uv_prod >>> 15);
  wire [17:0]        uv_abs    = next_uv[17] ? 18'(-next_uv) : next_uv;
  wire signed [9:0]  dtemp     = 10'(temp_q - IEM_TREF_C);
  wire signed [42:0] drift     = $signed({1'b0, cal_gain}) *
                                 $signed({1'b0, sense_resistor_tempco}) * dtemp;
  wire signed [54:0] drift_uo  = (55'(drift) * $signed({1'b0, IEM_DIV1000_MUL}))
                                 >>> IEM_DIV1000_SHR;
  wire signed [54:0] r_uohm    = $signed(55'(cal_gain) * 55'(IEM_THOUSAND)) + drift_uo;
  wire [31:0]        next_den  = (r_uohm < 55'sd1) ? 32'h1 : r_uohm[31:0];
  wire [31:0]        next_num  = 32'(uv_abs) * 32'(IEM_THOUSAND);
  // Divider step
  wire [32:0]        rem_sh    = {rem[31:0], dq[31]};
  wire [32:0]        rem_sub   = rem_sh - {1'b0, den};
  wire signed [31:0] next_iin  = neg ? 32'(-dq) : dq;
  wire signed [48:0] vi_prod   = $signed({1'b0, vin_q}) * iin_reading;
  wire signed [59:0] vi_scaled = (60'(vi_prod) * $signed({1'b0, IEM_DIV1000_MUL}))
                                 >>> IEM_DIV1000_SHR;
  wire signed [47:0] pe_prod   = 48'(pin_reading) * $signed({1'b0, ms_since});
  // Energy carry out of microjoule residue
  wire               frac_up   = energy_frac >= 48'sd1000;
  wire               frac_dn   = energy_frac <= -48'sd1000;
  wire               ms_tick   = tick_cnt == TW'(TICK_CYCLES - 1);

  // Bus slave
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if (ce) begin
      avs_waitrequest <= !bus_req;
      if (rd_acc) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      iin_range             <= IEM_RANGE_RST;
      cal_gain              <= IEM_CAL_GAIN_RST;
      sense_resistor_tempco <= IEM_TEMPCO_RST;
    end else if (ce && wr_acc) begin
      if (avs_address == IEM_CTRL_OFS)
        iin_range <= avs_writedata[IEM_CTRL_RANGE_LSB +: 2];
      if (avs_address == IEM_CAL_GAIN_OFS)
        cal_gain <= avs_writedata[15:0];
      if (avs_address == IEM_TEMPCO_OFS)
        sense_resistor_tempco <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tick_cnt    <= '0;
      energy_time <= 48'h0;
    end else if (ce) begin
      tick_cnt <= ms_tick ? '0 : tick_cnt + TW'(1);
      if (clear_e)
        energy_time <= 48'h0;
      else if (ms_tick)
        energy_time <= energy_time + 48'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      energy_hi_snap <= 16'h0;
      time_snap      <= 48'h0;
    end else if (ce && snap_e) begin
      energy_hi_snap <= energy_value[47:32];
      time_snap      <= energy_time;
    end
  end

  // Measurement sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state                 <= IEM_IDLE;
      vin_q                 <= 16'h0;
      code_q                <= 16'sh0;
      temp_q                <= 9'sh0;
      sense_uv              <= 18'sh0;
      den                   <= 32'h1;
      rem                   <= 33'h0;
      dq                    <= 32'h0;
      step                  <= 6'h0;
      neg                   <= 1'b0;
      iin_reading           <= 32'sh0;
      input_voltage_reading <= 16'h0;
      pin_reading           <= 32'sh0;
    end else if (ce) begin
      case (state)
        IEM_IDLE: begin
          if (sample_valid) begin
            vin_q  <= supply_voltage_sense_pin;
            code_q <= iin_sense_code;
            temp_q <= {die_temp_c[7], die_temp_c};
            state  <= IEM_SCALE;
          end
        end
        IEM_SCALE: begin
          sense_uv <= next_uv;
          neg      <= next_uv[17];
          den      <= next_den;
          dq       <= next_num;
          rem      <= 33'h0;
          step     <= 6'h0;
          state    <= IEM_DIVIDE;
        end
        IEM_DIVIDE: begin
          if (!rem_sub[32]) begin
            rem <= rem_sub;
            dq  <= {dq[30:0], 1'b1};
          end else begin
            rem <= rem_sh;
            dq  <= {dq[30:0], 1'b0};
          end
          step <= step + 6'h1;
          if (step == 6'd31)
            state <= IEM_POWER;
        end
        IEM_POWER: begin
          iin_reading           <= next_iin;
          input_voltage_reading <= vin_q;
          state                 <= IEM_ENERGY;
        end
        IEM_ENERGY: begin
          pin_reading <= 32'(vi_scaled);
          state       <= IEM_IDLE;
        end
        default: state <= IEM_IDLE;
      endcase
    end
  end

  // Energy accumulator
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      energy_value <= 48'h0;
      energy_frac  <= 48'sh0;
      ms_since     <= 16'h0;
    end else if (ce) begin
      if (clear_e) begin
        energy_value <= 48'h0;
        energy_frac  <= 48'sh0;
        ms_since     <= 16'h0;
      end else if (state == IEM_IDLE && sample_valid) begin
        energy_frac <= energy_frac + pe_prod;
        ms_since    <= ms_tick ? 16'h1 : 16'h0;
      end else begin
        if (ms_tick && ms_since != 16'hffff)
          ms_since <= ms_since + 16'h1;
        if (frac_up) begin
          energy_value <= energy_value + 48'h1;
          energy_frac  <= energy_frac - 48'sd1000;
        end else if (frac_dn) begin
          if (energy_value == 48'h0) begin
            energy_frac <= 48'sh0;
          end else begin
            energy_value <= energy_value - 48'h1;
            energy_frac  <= energy_frac + 48'sd1000;
          end
        end
      end
    end
  end

  wire unused_ok = &{1'b0, sense_uv, rem[32]};
endmodule
`default_nettype wire

/* iem_pkg.sv */
// Package for the input energy meter: register map, field layout,
// reset values, ranges and timing counts.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none
package iem_pkg;
  // Register byte offsets
  localparam logic [5:0] IEM_CTRL_OFS      = 6'h00;
  localparam logic [5:0] IEM_CAL_GAIN_OFS  = 6'h04;
  localparam logic [5:0] IEM_TEMPCO_OFS    = 6'h08;
  localparam logic [5:0] IEM_IIN_OFS       = 6'h0c;
  localparam logic [5:0] IEM_VIN_OFS       = 6'h10;
  localparam logic [5:0] IEM_PIN_OFS       = 6'h14;
  localparam logic [5:0] IEM_EVAL_LO_OFS   = 6'h18;
  localparam logic [5:0] IEM_EVAL_HI_OFS   = 6'h1c;
  localparam logic [5:0] IEM_ETIME_LO_OFS  = 6'h20;
  localparam logic [5:0] IEM_ETIME_HI_OFS  = 6'h24;
  localparam logic [5:0] IEM_STATUS_OFS    = 6'h28;
  // Control fields
  localparam int         IEM_CTRL_RANGE_LSB = 0;
  localparam int         IEM_CTRL_CLEAR_BIT = 8;
  // Reset values
  localparam logic [1:0]  IEM_RANGE_RST    = 2'h0;
  localparam logic [15:0] IEM_CAL_GAIN_RST = 16'h0001;
  localparam logic [15:0] IEM_TEMPCO_RST   = 16'h0000;
  // Amplifier ranges and their full scale in microvolts
  localparam logic [1:0]  IEM_RANGE_HIGH   = 2'h0;
  localparam logic [1:0]  IEM_RANGE_MED    = 2'h1;
  localparam logic [1:0]  IEM_RANGE_LOW    = 2'h2;
  localparam logic [16:0] IEM_FS_HIGH_UV   = 17'd100000;
  localparam logic [16:0] IEM_FS_MED_UV    = 17'd50000;
  localparam logic [16:0] IEM_FS_LOW_UV    = 17'd20000;
  // Scaling constants
  localparam logic [10:0] IEM_DIV1000_MUL  = 11'd1049;
  localparam int          IEM_DIV1000_SHR  = 20;
  localparam logic [9:0]  IEM_THOUSAND     = 10'd1000;
  localparam logic signed [8:0] IEM_TREF_C = 9'sd25;
  // Time base
  localparam int          IEM_CLK_HZ       = 10_000_000;
  localparam int          IEM_TICK_MS      = 1;
  localparam int          IEM_TICK_CYCLES  = IEM_CLK_HZ / 1000 * IEM_TICK_MS;
  localparam int          IEM_WIDTH_E      = 48;
  typedef enum logic [2:0] {
    IEM_IDLE, IEM_SCALE, IEM_DIVIDE, IEM_POWER, IEM_ENERGY
  } iem_state_t;
endpackage
`default_nettype wire

/* iem_sense_model.sv */
// Sense front end model: current, voltage and temperature samples every 40 cycles.
// Assumes the bench sets the analog values it wants sampled.
`timescale 1ns/1ps
`default_nettype none
module iem_sense_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Analog values
  input  wire logic [15:0] code,
  input  wire logic [15:0] mv,
  input  wire logic [7:0]  temp,
  // Sample outputs
  output logic             sample_valid,
  output logic [15:0]      supply_voltage_sense_pin,
  output logic [15:0]      iin_sense_code,
  output logic [7:0]       die_temp_c
);
  logic [5:0] cnt;
  always_ff @(posedge clk_sys) begin
    cnt <= (!nrst || cnt == 6'h27) ? 6'h0 : cnt + 6'h1;
    sample_valid <= nrst && cnt == 6'h27;
  end
  // sense values valid only with strobe
  assign supply_voltage_sense_pin = sample_valid ? mv : ~mv;
  assign iin_sense_code = sample_valid ? code : ~code;
  assign die_temp_c = sample_valid ? temp : ~temp;
endmodule
`default_nettype wire

/* iem_top_properties.sv */
// Checker for the energy meter register bus and readback.
// Assumes it is bound to iem_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module iem_top_chk
  import iem_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        ce,
  // Register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire take = ce && (avs_read || avs_write) && avs_waitrequest;
  wire rtake = take && avs_read;
  chk_wait_low: assert property (take |=> !avs_waitrequest)
    else $error("request not answered");
  chk_wait_single: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  chk_wait_idle: assert property (ce && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  chk_reset_quiet: assert property ($rose(nrst) |-> avs_waitrequest && avs_readdata == 32'h0)
    else $error("bus not idle after reset");
  chk_unmapped_zero: assert property (rtake && avs_address == 6'h3c |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_energy_width: assert property (rtake && avs_address == IEM_EVAL_HI_OFS
    |=> avs_readdata[31:16] == 16'h0)
    else $error("energy wider than 48 bits");
  chk_time_width: assert property (rtake && avs_address == IEM_ETIME_HI_OFS
    |=> avs_readdata[31:16] == 16'h0)
    else $error("time wider than 48 bits");
  chk_rdata_hold: assert property (!$past(rtake) |-> $stable(avs_readdata))
    else $error("read data changed without read");
endmodule
bind iem_top iem_top_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

/* iem_top_tb.sv */
// Testbench for the energy meter through its register bus.
// Assumes the design, sense model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module iem_top_tb
  import iem_pkg::*;
;
  logic        clk_sys, nrst, ce, rd, wr, wreq, sv;
  logic [5:0]  adr;
  logic [31:0] wd, rdat, d, e, t;
  logic [15:0] code, mv, vpin, icode;
  logic [7:0]  temp, tpin;
  logic [31:0] exp_i [3] = '{32'h1388, 32'h9c4, 32'h3e8};
  int          n_fail, n_compared;
  iem_sense_model PM (.clk_sys(clk_sys), .nrst(nrst), .code(code), .mv(mv), .temp(temp),
    .sample_valid(sv), .supply_voltage_sense_pin(vpin), .iin_sense_code(icode),
    .die_temp_c(tpin));
  iem_top #(.TICK_CYCLES(20)) DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .sample_valid(sv), .supply_voltage_sense_pin(vpin), .iin_sense_code(icode),
    .die_temp_c(tpin), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic chkb(input logic ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  // Microwatts to milliwatts through the package reciprocal of 1000
  function automatic logic [31:0] mw(input longint uw);
    mw = 32'((uw * longint'(IEM_DIV1000_MUL)) >>> IEM_DIV1000_SHR);
  endfunction
  task automatic acc(input logic [5:0] a, input logic w, input logic [31:0] v);
    int k;
    @(posedge clk_sys);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= v;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 40) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic cfg(input logic [5:0] a, input logic [31:0] v);
    acc(a, 1'b1, v);
    repeat (120) @(posedge clk_sys);
  endtask
  initial begin
    {nrst, rd, wr, adr, wd, code, mv} = '0;
    temp = 8'h19;
    ce = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(IEM_CAL_GAIN_OFS, 1'b0, 32'h0);
    chk(d, 32'h1);
    acc(IEM_TEMPCO_OFS, 1'b0, 32'h0);
    chk(d, 32'h0);
    acc(6'h3c, 1'b1, 32'hffff);
    acc(6'h3c, 1'b0, 32'h0);
    chk(d, 32'h0);
    $display("test registers done");
    acc(IEM_CAL_GAIN_OFS, 1'b1, 32'ha);
    code <= 16'h4000;
    mv <= 16'h2ee0;
    for (int r = 0; r < 3; r++) begin
      cfg(IEM_CTRL_OFS, 32'(r));
      acc(IEM_IIN_OFS, 1'b0, 32'h0);
      chk(d, exp_i[r]);
    end
    cfg(IEM_CTRL_OFS, 32'h0);
    acc(IEM_VIN_OFS, 1'b0, 32'h0);
    chk(d, 32'h2ee0);
    acc(IEM_PIN_OFS, 1'b0, 32'h0);
    chk(d, mw(12000 * 5000));
    code <= 16'hc000;
    cfg(IEM_TEMPCO_OFS, 32'h0);
    acc(IEM_IIN_OFS, 1'b0, 32'h0);
    chk(d, 32'hffffec78);
    acc(IEM_PIN_OFS, 1'b0, 32'h0);
    chk(d, mw(-12000 * 5000));
    code <= 16'h4000;
    temp <= 8'h4b;
    cfg(IEM_TEMPCO_OFS, 32'h0);
    acc(IEM_IIN_OFS, 1'b0, 32'h0);
    chk(d, 32'h1388);
    cfg(IEM_TEMPCO_OFS, 32'h3e8);
    acc(IEM_IIN_OFS, 1'b0, 32'h0);
    chk(d, 32'h1299);
    $display("test readings done");
    mv <= 16'h3e8;
    cfg(IEM_TEMPCO_OFS, 32'h0);
    acc(IEM_CTRL_OFS, 1'b1, 32'h100);
    repeat (2000) @(posedge clk_sys);
    acc(IEM_EVAL_LO_OFS, 1'b0, 32'h0);
    e = d;
    acc(IEM_ETIME_LO_OFS, 1'b0, 32'h0);
    t = d;
    chkb(t >= 32'h63 && t <= 32'h65);
    chkb(e <= 32'h5 * t + 32'ha && e + 32'h19 >= 32'h5 * t);
    acc(IEM_EVAL_HI_OFS, 1'b0, 32'h0);
    chk(d, 32'h0);
    acc(IEM_ETIME_HI_OFS, 1'b0, 32'h0);
    chk(d, 32'h0);
    code <= 16'hc000;
    repeat (400) @(posedge clk_sys);
    acc(IEM_EVAL_LO_OFS, 1'b0, 32'h0);
    chkb(d < e);
    repeat (3000) @(posedge clk_sys);
    acc(IEM_EVAL_LO_OFS, 1'b0, 32'h0);
    chk(d, 32'h0);
    acc(IEM_ETIME_LO_OFS, 1'b0, 32'h0);
    chkb(d > t);
    t = d;
    ce <= 1'b0;
    repeat (400) @(posedge clk_sys);
    ce <= 1'b1;
    acc(IEM_ETIME_LO_OFS, 1'b0, 32'h0);
    chkb(d - t <= 32'h1);
    $display("test energy done");
    report_and_stop();
  end
endmodule
`default_nettype wire
